//--- rtl/hbc_pkg.sv
`default_nettype none
package hbc_pkg;
    // Clock period, in ps
    localparam int unsigned CLK_PERIOD_PS = 8000;
    // Current-limit off time, typical, in ns
    localparam int unsigned OFF_TIME_NS = 20500;
    localparam int unsigned OFF_CYCLES = (OFF_TIME_NS * 1000) / CLK_PERIOD_PS;
    // Blanking time, typical, in ns
    localparam int unsigned BLANK_TIME_NS = 16500;
    localparam int unsigned BLANK_CYCLES = (BLANK_TIME_NS * 1000) / CLK_PERIOD_PS;
    // Timer width covers both counts
    localparam int unsigned TMR_W = 12;
    localparam logic [TMR_W-1:0] TMR_ZERO = 12'h000;
    localparam logic [TMR_W-1:0] OFF_LOAD = TMR_W'(OFF_CYCLES);
    localparam logic [TMR_W-1:0] BLANK_LOAD = TMR_W'(BLANK_CYCLES);
    // Synchroniser stage values after reset
    localparam logic [1:0] SYNC_RST = 2'h0;
    // Latch states
    typedef enum logic [1:0] {
        HBC_RUN = 2'b00,
        HBC_LATCHED = 2'b01,
        HBC_THERM_WAIT = 2'b10
    } hbc_state_type;
endpackage
`default_nettype wire

//--- rtl/hbc_sync.sv
`default_nettype none
// ------------------------------------------------------------
// Two-stage synchroniser, one per bit
// ------------------------------------------------------------
module hbc_sync #(
    parameter int unsigned W = 8
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    import hbc_pkg::*;
    logic [W-1:0] stage1;
    genvar g;
    // First stage feeds only the second
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    {stage1[g], o_sync[g]} <= SYNC_RST;
                end else begin
                    stage1[g] <= i_async[g];
                    o_sync[g] <= stage1[g];
                end
            end
        end
    endgenerate
endmodule // hbc_sync
`default_nettype wire

//--- rtl/hbc_bridge_ctrl.sv
`default_nettype none
// What this block does
// - Enabled, each leg follows its command
// - Equal commands drive both legs equal
// - Any disable tri-states legs, flag low
// - Short or overtemp latches tri-state, flag
// - Latch clears only by disable toggle
// - Undervoltage forces tri-state, flag low
// - Undervoltage recovery resumes automatically
// - Foldback above 160C, latch above 175C
// - Overcurrent turns stage off, no latch
// - Overcurrent during blanking is hard short
// - Fault flag open-drain, active low
// - Disable stops drivers, monitoring continues
// - Clear on disable edge, not level
// - Overcurrent off-time about twenty microseconds
// - Thermal restart only below hysteresis point
module hbc_bridge_ctrl (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_leg_a_command,
    input wire logic i_leg_b_command,
    input wire logic i_disable_high_active,
    input wire logic i_disable_low_active_n,
    input wire logic i_short_detect,
    input wire logic i_overtemp_detect,
    input wire logic i_temp_above_hyst,
    input wire logic i_undervoltage,
    input wire logic i_overcurrent,
    output logic o_leg_a_output,
    output logic o_leg_a_oe_n,
    output logic o_leg_b_output,
    output logic o_leg_b_oe_n,
    output logic o_fault_flag_n_out,
    output logic o_fault_flag_n_oe_n
);
    import hbc_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [8:0] raw_in;
    logic [8:0] syn;
    assign raw_in = {i_leg_a_command, i_leg_b_command, i_disable_high_active,
                     i_disable_low_active_n, i_short_detect, i_overtemp_detect,
                     i_temp_above_hyst, i_undervoltage, i_overcurrent};

    hbc_sync #(.W(9)) hbc_sync_inst (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_async(raw_in),
        .o_sync(syn)
    );

    wire cmd_a = syn[8];
    wire cmd_b = syn[7];
    wire dis_hi = syn[6];
    wire dis_lo_n = syn[5];
    wire short_det = syn[4];
    wire ot_det = syn[3];
    wire hot = syn[2];
    wire uv = syn[1];
    wire oc = syn[0];

    // ------------------------------------------------------------
    // Disable edge detection
    // ------------------------------------------------------------
    logic dis_hi_q;
    logic dis_lo_n_q;
    wire clear_edge = (dis_hi_q & ~dis_hi) | (~dis_lo_n_q & dis_lo_n);
    wire disabled = dis_hi | ~dis_lo_n;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            dis_hi_q <= 1'b1;
            dis_lo_n_q <= 1'b0;
        end else begin
            dis_hi_q <= dis_hi;
            dis_lo_n_q <= dis_lo_n;
        end
    end

    // ------------------------------------------------------------
    // Latch state machine and timers
    // ------------------------------------------------------------
    hbc_state_type state;
    hbc_state_type next_state;
    logic [TMR_W-1:0] off_tmr;
    logic [TMR_W-1:0] blank_tmr;
    logic drive_q;

    wire blanking = (blank_tmr != TMR_ZERO);
    wire off_active = (off_tmr != TMR_ZERO);
    wire hard_short = oc & blanking & drive_q;
    // latching causes; foldback itself sits in the analog detector
    wire latch_cause = short_det | ot_det | hard_short;

    // State decode; a new fault wins over a clear edge
    always_comb begin
        next_state = state;
        case (state)
            HBC_RUN: begin
                if (latch_cause) begin
                    next_state = HBC_LATCHED;
                end
            end
            HBC_LATCHED: begin
                if (!latch_cause && clear_edge) begin
                    next_state = hot ? HBC_THERM_WAIT : HBC_RUN;
                end
            end
            HBC_THERM_WAIT: begin
                if (latch_cause) begin
                    next_state = HBC_LATCHED;
                end else if (!hot) begin
                    next_state = HBC_RUN;
                end
            end
            default: next_state = HBC_LATCHED;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= HBC_RUN;
        end else begin
            state <= next_state;
        end
    end

    wire uv_block = uv;
    // gating; flag low when disabled or faulted
    wire fault_any = uv_block | (state != HBC_RUN) | disabled;
    wire drive_en = ~fault_any & ~off_active & ~latch_cause;
    wire oc_trip = drive_en & drive_q & oc & ~blanking;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            off_tmr <= TMR_ZERO;
        end else if (oc_trip) begin
            off_tmr <= OFF_LOAD;
        end else if (off_active) begin
            off_tmr <= off_tmr - 12'h001;
        end
    end

    // Blanking restarts at each activation
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            blank_tmr <= TMR_ZERO;
            drive_q <= 1'b0;
        end else begin
            drive_q <= drive_en;
            if (drive_en && !drive_q) begin
                blank_tmr <= BLANK_LOAD;
            end else if (blanking) begin
                blank_tmr <= blank_tmr - 12'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // legs follow commands; auto-resume via drive_en
    // flag released high via pull-up, pulled low on fault
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_leg_a_output <= 1'b0;
            o_leg_b_output <= 1'b0;
            o_leg_a_oe_n <= 1'b1;
            o_leg_b_oe_n <= 1'b1;
            o_fault_flag_n_out <= 1'b0;
            o_fault_flag_n_oe_n <= 1'b0;
        end else begin
            o_leg_a_output <= cmd_a & drive_en;
            o_leg_b_output <= cmd_b & drive_en;
            o_leg_a_oe_n <= ~drive_en;
            o_leg_b_oe_n <= ~drive_en;
            o_fault_flag_n_out <= 1'b0;
            o_fault_flag_n_oe_n <= ~fault_any;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_LEG_FOLLOW: assert property (@(posedge i_clk) disable iff (i_srst)
        drive_en |=> (o_leg_a_output == $past(cmd_a)) && !o_leg_a_oe_n)
        else $error("leg a does not follow command");
    AST_BRAKE_EQ: assert property (@(posedge i_clk) disable iff (i_srst)
        (drive_en && cmd_a == cmd_b) |=> (o_leg_a_output == o_leg_b_output))
        else $error("legs differ on equal commands");
    AST_DISABLE_Z: assert property (@(posedge i_clk) disable iff (i_srst)
        disabled |=> o_leg_a_oe_n && o_leg_b_oe_n && !o_fault_flag_n_oe_n)
        else $error("disable did not tri-state");
    AST_LATCH: assert property (@(posedge i_clk) disable iff (i_srst)
        (state == HBC_RUN && short_det) |=> state == HBC_LATCHED)
        else $error("short not latched");
    AST_STAY: assert property (@(posedge i_clk) disable iff (i_srst)
        (state == HBC_LATCHED && !clear_edge) |=> state == HBC_LATCHED)
        else $error("latch left without edge");
    AST_UV: assert property (@(posedge i_clk) disable iff (i_srst)
        uv |=> o_leg_a_oe_n && o_leg_b_oe_n && !o_fault_flag_n_oe_n)
        else $error("undervoltage did not tri-state");
    AST_OFFTIME: assert property (@(posedge i_clk) disable iff (i_srst)
        oc_trip |=> (off_tmr == OFF_LOAD) ##1 o_leg_a_oe_n [*8])
        else $error("off time not held");
    AST_THERM: assert property (@(posedge i_clk) disable iff (i_srst)
        (state == HBC_THERM_WAIT && hot) |=> state != HBC_RUN)
        else $error("restart while hot");
    COV_RUN: cover property (@(posedge i_clk) drive_en && cmd_a && !cmd_b);
    COV_CLEAR: cover property (@(posedge i_clk) state == HBC_LATCHED ##1 state == HBC_RUN);
    COV_OC: cover property (@(posedge i_clk) oc_trip);
endmodule // hbc_bridge_ctrl
`default_nettype wire

//--- tb/hbc_board.sv
`default_nettype none
// ----------------------------------------
// Board side: flag pull-up and leg pins
// ----------------------------------------
module hbc_board (
    input wire logic i_clk,
    input wire logic [2:0] i_oe_n,
    input wire logic [2:0] i_out,
    output logic [2:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] last = 2'h0;
    // Released legs float, so show a level that keeps changing
    always @(posedge i_clk) begin
        last <= o_pin[1:0];
    end
    assign o_pin[2] = i_oe_n[2] ? 1'b1 : i_out[2];
    assign o_pin[1] = i_oe_n[1] ? ~last[1] : i_out[1];
    assign o_pin[0] = i_oe_n[0] ? ~last[0] : i_out[0];
endmodule // hbc_board
`default_nettype wire

//--- tb/hbc_bridge_ctrl_tb.sv
`default_nettype none
module hbc_bridge_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hbc_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [4:0] ZZ = 5'h0a; // Flag low, both legs released
    localparam logic [4:0] OFF = 5'h1a; // Flag released, both legs released
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ca, cb, dh, dln, sc, ot, hy, uv, oc;
    logic a, aoe, b, boe, fo, foe;
    logic [2:0] pin;
    logic [5:0] q[$];
    logic [31:0] seed = 32'd48280;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    event smp;
    always #4 clk = ~clk;
    hbc_bridge_ctrl hbc_bridge_ctrl_inst (.i_clk(clk), .i_srst(srst),
        .i_leg_a_command(ca), .i_leg_b_command(cb), .i_disable_high_active(dh),
        .i_disable_low_active_n(dln), .i_short_detect(sc), .i_overtemp_detect(ot),
        .i_temp_above_hyst(hy), .i_undervoltage(uv), .i_overcurrent(oc),
        .o_leg_a_output(a), .o_leg_a_oe_n(aoe), .o_leg_b_output(b), .o_leg_b_oe_n(boe),
        .o_fault_flag_n_out(fo), .o_fault_flag_n_oe_n(foe));
    hbc_board hbc_board_inst (.i_clk(clk), .i_oe_n({foe, boe, aoe}), .i_out({fo, b, a}),
        .o_pin(pin));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [4:0] run(input logic x, input logic y);
        return {1'b1, 1'b0, x, 1'b0, y};
    endfunction
    // Let the two sync stages and output register settle, then note
    task automatic chk(input logic [4:0] e, input logic f);
        repeat (5) @(negedge clk);
        q.push_back({f, e});
        -> smp;
    endtask
    task automatic pulse_oc();
        oc = 1'b1;
        @(negedge clk);
        oc = 1'b0;
    endtask
    task automatic end_of_test();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Monitor: oldest note against what the pins show
    always @(smp) begin
        logic [5:0] n;
        logic [4:0] o;
        n = q.pop_front();
        o = {pin[2], aoe, aoe ? 1'b0 : pin[0], boe, boe ? 1'b0 : pin[1]};
        if (!n[5]) o[4] = n[4]; // Flag left open by this note
        cmp_count++;
        if (o !== n[4:0]) begin
            error_cnt++;
            $display("[ERR] %0t exp %h got %h", $time, n[4:0], o);
        end
    end
    // Watchdog against a hung run
    always @(posedge clk) begin
        cyc++;
        if (cyc > 90000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {ca, cb, dh, dln, sc, ot, hy, uv, oc} = 9'h060;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        chk(ZZ, 1'b1);
        dh = 1'b0;
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            {ca, cb} = (i < 4) ? i[1:0] : seed[1:0];
            chk(run(ca, cb), 1'b1);
        end
        {ca, cb, dh} = 3'b101;
        chk(ZZ, 1'b1);
        {dh, dln} = 2'b00;
        chk(ZZ, 1'b1);
        dln = 1'b1;
        chk(run(1'b1, 1'b0), 1'b1);
        // Short, then overtemperature still hot at clear time
        for (int k = 0; k < 2; k++) begin
            {sc, ot, hy} = k ? 3'b011 : 3'b100;
            chk(ZZ, 1'b1);
            {sc, ot} = 2'b00;
            chk(ZZ, 1'b1);
            dh = 1'b1;
            chk(ZZ, 1'b1);
            dh = 1'b0;
            chk(k ? ZZ : run(1'b1, 1'b0), 1'b1);
            hy = 1'b0;
            chk(run(1'b1, 1'b0), 1'b1);
        end
        uv = 1'b1;
        chk(ZZ, 1'b1);
        uv = 1'b0;
        chk(run(1'b1, 1'b0), 1'b1);
        sc = 1'b1;
        chk(ZZ, 1'b1);
        {sc, uv, dh} = 3'b011;
        chk(ZZ, 1'b1);
        dh = 1'b0;
        chk(ZZ, 1'b1);
        uv = 1'b0;
        chk(run(1'b1, 1'b0), 1'b1);
        // Overcurrent after blanking: off-time only, no latch
        repeat (BLANK_CYCLES + 20) @(negedge clk);
        pulse_oc();
        chk(OFF, 1'b1);
        repeat (OFF_CYCLES - 200) @(negedge clk);
        chk(OFF, 1'b1);
        repeat (300) @(negedge clk);
        chk(run(1'b1, 1'b0), 1'b1);
        // Overcurrent inside blanking after a fresh activation
        dh = 1'b1;
        chk(ZZ, 1'b1);
        dh = 1'b0;
        chk(run(1'b1, 1'b0), 1'b1);
        pulse_oc();
        repeat (OFF_CYCLES + 100) @(negedge clk);
        chk(ZZ, 1'b1);
        dln = 1'b0;
        chk(ZZ, 1'b1);
        dln = 1'b1;
        chk(run(1'b1, 1'b0), 1'b1);
        // Overtemperature while disabled must still latch
        dh = 1'b1;
        {ot, hy} = 2'b11;
        chk(ZZ, 1'b1);
        {ot, dh} = 2'b00;
        chk(ZZ, 1'b1);
        hy = 1'b0;
        chk(run(1'b1, 1'b0), 1'b1);
        end_of_test();
    end
endmodule // hbc_bridge_ctrl_tb
`default_nettype wire
